// ### hdl/iev_exception_unit.sv
`timescale 1ns/1ns
// What this block does
// - reset vectors at once, nmi disabled after
// - nmi beats peripherals and software exceptions
// - peripheral taken only when level above mask
// - mask all ones refuses every peripheral
// - software exception entry forces mask ones
// - trap number in opcode picks vector
// - illegal and unimplemented opcodes use offset zero
// - table at fixed base, offset added
// - peripherals supply offset; nmi and others internal
// - handler word address shifted, bit zero low
// - nmi held pending, not taken, during nmi or after reset
// - enabled pending nmi taken at next boundary
// - return, trap or mask clear re-enable nmi
// - after nmi, all ones mask blocks requests
// - push status, add two, push pc, add two
// - pushed pc is next word plus two
// - every entry sets mask to all ones
// - software exceptions taken without arbitration
// - all sources share one vector table
module iev_exception_unit
(
   // clock and reset
   input wire logic clk,
   input wire logic rst,
   // external nonmaskable pin, asynchronous
   input wire logic nmi_pin,
   // peripheral requests
   input wire iev_pkg::iev_src_t periph_src [iev_pkg::IEV_N_SRC],
   // core execution events
   input wire logic instr_boundary,
   input wire logic trap_exec,
   input wire logic [7:0] trap_number,
   input wire logic illegal_exec,
   input wire logic return_from_service,
   input wire logic level_mask_load_instr,
   input wire logic [2:0] level_mask_wdata,
   // core context
   input wire logic [15:0] status_word,
   input wire logic [15:0] program_counter,
   input wire logic [15:0] stack_pointer,
   // memory port
   output iev_pkg::iev_mem_t mem_out,
   input wire logic mem_ack,
   input wire logic [15:0] mem_rdata,
   // results toward the core
   output logic busy,
   output logic pc_load,
   output logic [16:0] pc_load_addr,
   output logic sp_load,
   output logic [15:0] sp_value,
   output logic [2:0] interrupt_level_mask,
   // acknowledges toward requesters
   output logic nmi_ack,
   output logic [iev_pkg::IEV_N_SRC-1:0] periph_ack
);
   import iev_pkg::*;

   // ----------------------------------------------------------------
   // state
   // ----------------------------------------------------------------
   iev_state_t state_reg, state_next;        // entry sequencer
   iev_kind_t kind_reg, kind_next;           // source of this entry
   iev_mem_t mem_reg, mem_next;              // memory request
   logic [2:0] mask_reg, mask_next;          // interrupt_level_mask
   logic nmi_en_reg, nmi_en_next;            // nmi recognition armed
   logic nmi_pend_reg, nmi_pend_next;        // nmi edge seen, not taken
   logic exc_pend_reg, exc_pend_next;        // software exception waiting
   logic [7:0] exc_ofs_reg, exc_ofs_next;    // its internal offset
   logic [7:0] ofs_reg, ofs_next;            // offset of this entry
   logic [15:0] sp_reg, sp_next;             // working stack pointer
   logic [15:0] pc_reg, pc_next;             // pc to be pushed
   logic busy_reg, busy_next;
   logic pc_load_reg, pc_load_next;
   logic [16:0] pc_addr_reg, pc_addr_next;
   logic sp_load_reg, sp_load_next;
   logic nmi_ack_reg, nmi_ack_next;
   logic [IEV_N_SRC-1:0] pack_reg, pack_next;
   // nmi pin synchroniser and edge history
   logic nmi_meta_reg, nmi_sync_reg, nmi_prev_reg;

   // arbiter results
   logic arb_valid;
   logic [IEV_N_SRC-1:0] arb_grant;
   logic [7:0] arb_offset;
   logic [2:0] arb_level;

   // derived events
   logic nmi_edge;                           // rising edge of synced pin
   logic rearm;                              // any nmi re-enable event
   logic [15:0] st_push;                     // status word image pushed

   iev_level_arb u_arb
   (
      .src(periph_src),
      .mask(mask_reg),
      .valid(arb_valid),
      .grant(arb_grant),
      .offset(arb_offset),
      .level(arb_level)
   );

   // only the second stage feeds the edge detector
   assign nmi_edge = nmi_sync_reg & ~nmi_prev_reg;

   // return, trap, or a mask write that clears any set bit
   assign rearm = return_from_service | trap_exec
      | (level_mask_load_instr && ((mask_reg & ~level_mask_wdata) != 3'h0));

   // status image carries the mask as it was before entry
   always_comb
   begin
      st_push = status_word;
      st_push[IEV_MASK_MSB:IEV_MASK_LSB] = mask_reg;
   end

   // ----------------------------------------------------------------
   // next-state logic
   // ----------------------------------------------------------------
   always_comb
   begin
      state_next = state_reg;
      kind_next = kind_reg;
      mem_next = mem_reg;
      mask_next = mask_reg;
      nmi_en_next = nmi_en_reg;
      exc_ofs_next = exc_ofs_reg;
      ofs_next = ofs_reg;
      sp_next = sp_reg;
      pc_next = pc_reg;
      busy_next = busy_reg;
      pc_addr_next = pc_addr_reg;
      pc_load_next = 1'b0;
      sp_load_next = 1'b0;
      nmi_ack_next = 1'b0;
      pack_next = '0;
      // a new edge in the take cycle survives the clear
      nmi_pend_next = nmi_pend_reg | nmi_edge;
      exc_pend_next = exc_pend_reg;

      // software exceptions latch with their own offset
      if (trap_exec)
      begin
         exc_pend_next = 1'b1;
         exc_ofs_next = trap_number;
      end
      else if (illegal_exec)
      begin
         exc_pend_next = 1'b1;
         exc_ofs_next = IEV_OFS_ILLEGAL;
      end

      // mask writes from the core, only between entries
      if (state_reg == S_IDLE && level_mask_load_instr)
      begin
         mask_next = level_mask_wdata;
      end
      // re-arm nmi; a pending edge is then taken normally
      if (rearm)
      begin
         nmi_en_next = 1'b1;
      end

      case (state_reg)
         S_IDLE:
         begin
            // nmi first, then exceptions, then peripherals
            if (nmi_pend_reg && nmi_en_reg && instr_boundary)
            begin
               kind_next = K_NMI;
               ofs_next = IEV_OFS_NMI;
               nmi_pend_next = nmi_edge;
               nmi_en_next = 1'b0;
               nmi_ack_next = 1'b1;
            end
            else if (exc_pend_reg)
            begin
               kind_next = K_EXC;
               ofs_next = exc_ofs_reg;
               exc_pend_next = trap_exec | illegal_exec;
            end
            else if (arb_valid && instr_boundary)
            begin
               kind_next = K_PERIPH;
               ofs_next = arb_offset;
               pack_next = arb_grant;
            end
            if ((nmi_pend_reg && nmi_en_reg && instr_boundary) || exc_pend_reg
               || (arb_valid && instr_boundary))
            begin
               // context save starts with the status word
               mask_next = IEV_MASK_ALL;
               busy_next = 1'b1;
               sp_next = stack_pointer;
               pc_next = program_counter + IEV_PC_AHEAD;
               mem_next = '{req: 1'b1, we: 1'b1, addr: {1'b0, stack_pointer},
                  wdata: st_push};
               state_next = S_PUSH_ST;
            end
         end
         S_PUSH_ST:
         begin
            if (mem_ack)
            begin
               sp_next = sp_reg + IEV_SP_STEP;
               mem_next = '{req: 1'b1, we: 1'b1,
                  addr: {1'b0, sp_reg + IEV_SP_STEP}, wdata: pc_reg};
               state_next = S_PUSH_PC;
            end
         end
         S_PUSH_PC:
         begin
            if (mem_ack)
            begin
               sp_next = sp_reg + IEV_SP_STEP;
               mem_next = '{req: 1'b1, we: 1'b0, addr: iev_vec_addr(ofs_reg),
                  wdata: 16'h0000};
               state_next = S_VEC_RD;
            end
         end
         S_VEC_RD:
         begin
            if (mem_ack)
            begin
               // word address handed over as a byte address
               pc_addr_next = {mem_rdata, 1'b0};
               pc_load_next = 1'b1;
               // reset never pushed, so the stack is left alone
               sp_load_next = (kind_reg != K_RESET);
               mem_next = '{req: 1'b0, we: 1'b0, addr: 17'h00000, wdata: 16'h0000};
               busy_next = 1'b0;
               state_next = S_IDLE;
            end
         end
         default:
         begin
            state_next = S_IDLE;
            busy_next = 1'b0;
         end
      endcase
   end

   // ----------------------------------------------------------------
   // registers; reset goes straight to the reset vector read
   // ----------------------------------------------------------------
   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         state_reg <= S_VEC_RD;
         kind_reg <= K_RESET;
         mem_reg <= '{req: 1'b1, we: 1'b0, addr: IEV_VEC_BASE + {8'h00, IEV_OFS_RESET, 1'b0},
            wdata: 16'h0000};
         mask_reg <= IEV_MASK_ALL;
         nmi_en_reg <= 1'b0;
         nmi_pend_reg <= 1'b0;
         exc_pend_reg <= 1'b0;
         exc_ofs_reg <= 8'h00;
         ofs_reg <= IEV_OFS_RESET;
         sp_reg <= 16'h0000;
         pc_reg <= 16'h0000;
         busy_reg <= 1'b1;
         pc_load_reg <= 1'b0;
         pc_addr_reg <= 17'h00000;
         sp_load_reg <= 1'b0;
         nmi_ack_reg <= 1'b0;
         pack_reg <= '0;
         nmi_meta_reg <= 1'b0;
         nmi_sync_reg <= 1'b0;
         nmi_prev_reg <= 1'b0;
      end
      else
      begin
         state_reg <= state_next;
         kind_reg <= kind_next;
         mem_reg <= mem_next;
         mask_reg <= mask_next;
         nmi_en_reg <= nmi_en_next;
         nmi_pend_reg <= nmi_pend_next;
         exc_pend_reg <= exc_pend_next;
         exc_ofs_reg <= exc_ofs_next;
         ofs_reg <= ofs_next;
         sp_reg <= sp_next;
         pc_reg <= pc_next;
         busy_reg <= busy_next;
         pc_load_reg <= pc_load_next;
         pc_addr_reg <= pc_addr_next;
         sp_load_reg <= sp_load_next;
         nmi_ack_reg <= nmi_ack_next;
         pack_reg <= pack_next;
         nmi_meta_reg <= nmi_pin;
         nmi_sync_reg <= nmi_meta_reg;
         nmi_prev_reg <= nmi_sync_reg;
      end
   end

   // outputs come straight from flops
   assign mem_out = mem_reg;
   assign busy = busy_reg;
   assign pc_load = pc_load_reg;
   assign pc_load_addr = pc_addr_reg;
   assign sp_load = sp_load_reg;
   assign sp_value = sp_reg;
   assign interrupt_level_mask = mask_reg;
   assign nmi_ack = nmi_ack_reg;
   assign periph_ack = pack_reg;

   // ----------------------------------------------------------------
   // assertions
   // ----------------------------------------------------------------
   default clocking cb @(posedge clk); endclocking
   default disable iff (rst);

   a_reset_slot: assert property ((kind_reg == K_RESET && state_reg == S_VEC_RD)
      |-> mem_reg.addr == 17'h08002 && !mem_reg.we)
      else $error("reset vector read not at reset slot");
   a_nmi_slot: assert property ((state_reg == S_VEC_RD && kind_reg == K_NMI)
      |-> mem_reg.addr == 17'h08006)
      else $error("nmi vector read not at nmi slot");
   a_full_mask_refuse: assert property ((mask_reg == 3'h7) |=> periph_ack == '0)
      else $error("peripheral acknowledged under full mask");
   a_level_above: assert property ((state_reg == S_IDLE && arb_valid && instr_boundary
      && !exc_pend_reg && !(nmi_pend_reg && nmi_en_reg))
      |-> arb_level > mask_reg ##1 periph_ack != '0)
      else $error("peripheral level not above mask");
   a_entry_mask: assert property ((state_reg == S_IDLE && $fell(state_reg == S_IDLE) == 1'b0
      && state_next == S_PUSH_ST) |=> mask_reg == 3'h7)
      else $error("mask not forced on entry");
   a_nmi_lockout: assert property (nmi_ack_reg |-> !nmi_en_reg)
      else $error("nmi still armed after nmi entry");
   a_push_order: assert property ((state_reg == S_PUSH_ST && mem_ack)
      |=> mem_reg.we && mem_reg.addr == {1'b0, $past(sp_reg) + 16'h0002}
      && mem_reg.wdata == pc_reg)
      else $error("pc push not two bytes above status push");
   a_pc_ahead: assert property ((state_reg == S_IDLE && state_next == S_PUSH_ST)
      |=> pc_reg == $past(program_counter) + 16'h0002)
      else $error("pushed pc not two words ahead");
   a_exc_vector: assert property ((state_reg == S_VEC_RD && kind_reg != K_RESET)
      |-> mem_reg.addr == 17'h08000 + {8'h00, ofs_reg, 1'b0})
      else $error("vector address not base plus offset");
   a_handler_even: assert property (pc_load_reg |-> pc_addr_reg[0] == 1'b0
      && $past(state_reg) == S_VEC_RD)
      else $error("handler address odd or out of sequence");
   a_trap_rearm: assert property ((trap_exec || return_from_service) |=> nmi_en_reg)
      else $error("nmi not re-armed");

   c_nmi_entry: cover property (nmi_ack_reg ##[1:40] pc_load_reg);
   c_periph_entry: cover property ((periph_ack != '0) ##[1:40] pc_load_reg);
   c_trap_entry: cover property (trap_exec ##[1:40] pc_load_reg);
   c_nmi_after_rti: cover property (return_from_service ##[1:20] nmi_ack_reg);

endmodule : iev_exception_unit

// ### hdl/iev_level_arb.sv
`timescale 1ns/1ns
// ----------------------------------------------------------------
// peripheral level arbiter: highest unmasked level wins
// ----------------------------------------------------------------
module iev_level_arb
(
   // requests from peripheral modules
   input wire iev_pkg::iev_src_t src [iev_pkg::IEV_N_SRC],
   // current level mask
   input wire logic [2:0] mask,
   // winner
   output logic valid,
   output logic [iev_pkg::IEV_N_SRC-1:0] grant,
   output logic [7:0] offset,
   output logic [2:0] level
);
   import iev_pkg::*;

   // per-slot eligibility, one gate per source
   logic [IEV_N_SRC-1:0] elig;

   genvar g;
   generate
      for (g = 0; g < IEV_N_SRC; g++)
      begin : g_elig
         // strictly above the mask, so a mask of all ones refuses all
         assign elig[g] = src[g].req & iev_unmasked(src[g].level, mask);
      end
   endgenerate

   // ----------------------------------------------------------------
   // pick highest level; ties go to the lowest slot
   // ----------------------------------------------------------------
   always_comb
   begin
      valid = 1'b0;
      grant = '0;
      offset = 8'h00;
      level = 3'h0;
      for (int i = 0; i < IEV_N_SRC; i++)
      begin
         // strict compare keeps the earlier slot on a tie
         if (elig[i] && (!valid || src[i].level > level))
         begin
            valid = 1'b1;
            grant = '0;
            grant[i] = 1'b1;
            offset = src[i].offset;
            level = src[i].level;
         end
      end
   end

endmodule : iev_level_arb

// ### shared/iev_pkg.sv
// ----------------------------------------------------------------
// interrupt and exception vectoring constants and types
// ----------------------------------------------------------------
package iev_pkg;

   // ----------------------------------------------------------------
   // sizes
   // ----------------------------------------------------------------
   localparam int IEV_N_SRC = 8;              // peripheral request slots
   localparam int IEV_LVL_W = 3;              // level and mask width
   localparam int IEV_OFS_W = 8;              // vector offset width
   localparam int IEV_ADDR_W = 17;            // physical byte address
   localparam int IEV_WORD_W = 16;            // data and word address

   // ----------------------------------------------------------------
   // vector table
   // ----------------------------------------------------------------
   localparam logic [16:0] IEV_VEC_BASE = 17'h08000;   // table base
   localparam logic [7:0] IEV_OFS_RESET = 8'h01;        // slot at 08002h
   localparam logic [7:0] IEV_OFS_NMI = 8'h03;          // slot at 08006h
   localparam logic [7:0] IEV_OFS_ILLEGAL = 8'h00;      // same as trap 0

   // ----------------------------------------------------------------
   // status word and stack arithmetic
   // ----------------------------------------------------------------
   localparam logic [2:0] IEV_MASK_ALL = 3'h7;          // all levels masked
   localparam int IEV_MASK_LSB = 0;                     // mask field in status
   localparam int IEV_MASK_MSB = 2;
   localparam logic [15:0] IEV_SP_STEP = 16'h0002;      // bytes per push
   localparam logic [15:0] IEV_PC_AHEAD = 16'h0002;     // prefetch, in words

   // ----------------------------------------------------------------
   // types
   // ----------------------------------------------------------------
   // one peripheral request with the offset it offers at acknowledge
   typedef struct packed {
      logic req;
      logic [2:0] level;
      logic [7:0] offset;
   } iev_src_t;

   // memory request toward the core's data path
   typedef struct packed {
      logic req;
      logic we;
      logic [16:0] addr;
      logic [15:0] wdata;
   } iev_mem_t;

   // entry sequencer states
   typedef enum logic [2:0] {S_IDLE, S_PUSH_ST, S_PUSH_PC, S_VEC_RD} iev_state_t;

   // what started the current entry
   typedef enum logic [1:0] {K_RESET, K_NMI, K_EXC, K_PERIPH} iev_kind_t;

   // ----------------------------------------------------------------
   // functions
   // ----------------------------------------------------------------
   // a level passes only when strictly above the mask
   function automatic logic iev_unmasked(input logic [2:0] level, input logic [2:0] mask);
      iev_unmasked = (level > mask);
   endfunction : iev_unmasked

   // byte address of a vector slot
   function automatic logic [16:0] iev_vec_addr(input logic [7:0] ofs);
      iev_vec_addr = IEV_VEC_BASE + {8'h00, ofs, 1'b0};
   endfunction : iev_vec_addr

endpackage : iev_pkg

// ### verification/iev_src_model.sv
`timescale 1ns/1ns
// ----------------------------------------------------------------
// peripheral request sources and external nmi pin
// ----------------------------------------------------------------
module iev_src_model
(
   // clock
   input wire logic clk,
   // acknowledges from the unit
   input wire logic [iev_pkg::IEV_N_SRC-1:0] periph_ack,
   // requests toward the unit
   output iev_pkg::iev_src_t periph_src [iev_pkg::IEV_N_SRC],
   output logic nmi_pin
);
   import iev_pkg::*;

   // quiet start, nothing requested
   initial
   begin
      nmi_pin = 1'b0;
      for (int i = 0; i < IEV_N_SRC; i++)
         periph_src[i] = '0;
   end

   // a source holds level and offset until acknowledged, then lets go
   always @(posedge clk)
   begin
      for (int i = 0; i < IEV_N_SRC; i++)
      begin
         if (periph_ack[i])
         begin
            periph_src[i].req <= 1'b0;
            // released offset flips, so a late sample shows garbage
            periph_src[i].offset <= ~periph_src[i].offset;
         end
      end
   end

   // raise one level request with its vector offset
   task automatic raise(input int slot, input logic [2:0] lvl, input logic [7:0] ofs);
      @(posedge clk);
      periph_src[slot] <= '{req: 1'b1, level: lvl, offset: ofs};
   endtask : raise

   // short high pulse on the pin; the unit keys on the edge
   task automatic nmi_pulse();
      @(posedge clk);
      nmi_pin <= 1'b1;
      repeat (4) @(posedge clk);
      nmi_pin <= 1'b0;
   endtask : nmi_pulse

endmodule : iev_src_model

// ### verification/interrupt_exception_vectoring_tb_top.sv
`timescale 1ns/1ns
// ----------------------------------------------------------------
// self-checking bench for the exception unit
// ----------------------------------------------------------------
module interrupt_exception_vectoring_tb_top;
   import iev_pkg::*;

   logic clk, rst, nmi_pin, instr_boundary, trap_exec, illegal_exec, rfs, lm_wr, mem_ack;
   logic [7:0] trap_number;
   logic [2:0] lm_wdata, interrupt_level_mask;
   logic [15:0] status_word, program_counter, stack_pointer, mem_rdata, sp_value;
   logic busy, pc_load, sp_load, nmi_ack;
   logic [16:0] pc_load_addr;
   logic [IEV_N_SRC-1:0] periph_ack;
   iev_src_t periph_src [IEV_N_SRC];
   iev_mem_t mem_out;
   int failures = 0;
   int n_compared = 0;
   int cycles = 0;

   // ----------------------------------------------------------------
   // clock, far side and unit
   // ----------------------------------------------------------------
   initial
   begin
      clk = 1'b0;
      forever #50 clk = ~clk;
   end

   iev_src_model SRC (.clk(clk), .periph_ack(periph_ack), .periph_src(periph_src),
      .nmi_pin(nmi_pin));

   iev_exception_unit DUT (.clk(clk), .rst(rst), .nmi_pin(nmi_pin), .periph_src(periph_src),
      .instr_boundary(instr_boundary), .trap_exec(trap_exec), .trap_number(trap_number),
      .illegal_exec(illegal_exec), .return_from_service(rfs), .level_mask_load_instr(lm_wr),
      .level_mask_wdata(lm_wdata), .status_word(status_word),
      .program_counter(program_counter), .stack_pointer(stack_pointer), .mem_out(mem_out),
      .mem_ack(mem_ack), .mem_rdata(mem_rdata), .busy(busy), .pc_load(pc_load),
      .pc_load_addr(pc_load_addr), .sp_load(sp_load), .sp_value(sp_value),
      .interrupt_level_mask(interrupt_level_mask), .nmi_ack(nmi_ack), .periph_ack(periph_ack));

   // ----------------------------------------------------------------
   // shared tasks
   // ----------------------------------------------------------------
   task automatic end_of_test();
      if (failures == 0 && n_compared > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask : end_of_test

   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      n_compared++;
      if (seen !== exp)
      begin
         failures++;
         $display("ERROR t=%0t seen %h expected %h", $time, seen, exp);
      end
   endtask : chk

   // hang guard, far above the longest sequence
   always @(posedge clk)
   begin
      cycles++;
      if (cycles == 3000)
      begin
         failures++;
         end_of_test();
      end
   end

   // one memory access: wait, judge, then ack with the request held
   task automatic mem_step(input logic we, input logic [16:0] addr, input logic [15:0] wd,
      input logic [15:0] rd, input logic [8:0] acks);
      for (int i = 0; i < 60 && mem_out.req !== 1'b1; i++)
      begin
         #1;
         if (mem_out.req !== 1'b1)
            @(posedge clk);
      end
      chk({mem_out.req, mem_out.we, mem_out.addr}, {1'b1, we, addr});
      if (we)
         chk(mem_out.wdata, wd);
      chk({nmi_ack, periph_ack}, acks);
      @(posedge clk);
      mem_ack <= 1'b1;
      mem_rdata <= rd;
      @(posedge clk);
      mem_ack <= 1'b0;
      mem_rdata <= ~rd;
      #1;
   endtask : mem_step

   // full entry: two pushes, vector read, then program counter load
   task automatic entry(input logic [7:0] ofs, input logic [8:0] acks);
      logic [15:0] h;
      h = 16'h4000 ^ {8'h00, ofs};
      mem_step(1'b1, {1'b0, stack_pointer}, status_word, 16'h0000, acks);
      mem_step(1'b1, {1'b0, stack_pointer} + 17'h00002, program_counter + 16'h0002,
         16'h0000, 9'h000);
      mem_step(1'b0, 17'h08000 + {8'h00, ofs, 1'b0}, 16'h0000, h, 9'h000);
      chk({pc_load, pc_load_addr}, {1'b1, h, 1'b0});
      chk({sp_load, sp_value}, {1'b1, stack_pointer + 16'h0004});
      chk({busy, interrupt_level_mask}, {1'b0, 3'h7});
      // core status now holds the all-ones mask, so the next push images it
      status_word <= {status_word[15:3], IEV_MASK_ALL};
   endtask : entry

   // no entry may start for n cycles
   task automatic no_entry(input int n);
      repeat (n)
      begin
         @(posedge clk);
         #1;
         chk({busy, nmi_ack, periph_ack}, 10'h000);
      end
   endtask : no_entry

   // core mask write; status image follows the new mask
   task automatic set_mask(input logic [2:0] m);
      @(posedge clk);
      lm_wr <= 1'b1;
      lm_wdata <= m;
      status_word <= {13'h0acf, m};
      @(posedge clk);
      lm_wr <= 1'b0;
   endtask : set_mask

   task automatic pulse_rfs();
      @(posedge clk);
      rfs <= 1'b1;
      status_word <= 16'h567f;
      @(posedge clk);
      rfs <= 1'b0;
   endtask : pulse_rfs

   // ----------------------------------------------------------------
   // scenarios
   // ----------------------------------------------------------------
   // reset fetch only, from the reset slot
   task automatic t_reset();
      chk({busy, interrupt_level_mask}, {1'b1, 3'h7});
      mem_step(1'b0, 17'h08002, 16'h0000, 16'h4001, 9'h000);
      chk({pc_load, pc_load_addr, sp_load, busy}, {1'b1, 16'h4001, 1'b0, 1'b0, 1'b0});
   endtask : t_reset

   // nmi disarmed after reset, armed by clearing mask, locked while served
   task automatic t_nmi_lock();
      SRC.raise(0, 3'h7, 8'h11);
      SRC.nmi_pulse();
      no_entry(8);
      stack_pointer <= 16'h0200;
      set_mask(3'h0);
      entry(IEV_OFS_NMI, 9'h100);
      SRC.nmi_pulse();
      no_entry(8);
      pulse_rfs();
      entry(IEV_OFS_NMI, 9'h100);
   endtask : t_nmi_lock

   // levels against mask, highest level then lowest slot
   task automatic t_periph();
      SRC.raise(1, 3'h6, 8'h21);
      SRC.raise(5, 3'h6, 8'h25);
      SRC.raise(2, 3'h3, 8'h32);
      set_mask(3'h3);
      entry(8'h11, 9'h001);
      set_mask(3'h3);
      entry(8'h21, 9'h002);
      set_mask(3'h5);
      entry(8'h25, 9'h020);
      set_mask(3'h3);
      no_entry(6);
   endtask : t_periph

   // traps and illegal opcodes, taken off the boundary
   task automatic t_trap();
      logic [7:0] nums [3] = '{8'h00, 8'h7f, 8'hff};
      instr_boundary <= 1'b0;
      set_mask(3'h2);
      foreach (nums[i])
      begin
         @(posedge clk);
         trap_exec <= 1'b1;
         trap_number <= nums[i];
         @(posedge clk);
         trap_exec <= 1'b0;
         entry(nums[i], 9'h000);
      end
      @(posedge clk);
      illegal_exec <= 1'b1;
      @(posedge clk);
      illegal_exec <= 1'b0;
      entry(IEV_OFS_ILLEGAL, 9'h000);
   endtask : t_trap

   // ----------------------------------------------------------------
   // main sequence
   // ----------------------------------------------------------------
   initial
   begin
      rst = 1'b1;
      instr_boundary = 1'b1;
      {trap_exec, illegal_exec, rfs, lm_wr, mem_ack} = 5'h00;
      trap_number = 8'h00;
      lm_wdata = 3'h7;
      status_word = 16'h567f;
      program_counter = 16'h1230;
      stack_pointer = 16'h0000;
      mem_rdata = 16'h0000;
      repeat (20) @(posedge clk);
      rst <= 1'b0;
      t_reset();
      t_nmi_lock();
      t_periph();
      t_trap();
      end_of_test();
   end

endmodule : interrupt_exception_vectoring_tb_top
